// ---- rtl/cpwm_pkg.sv ----
// constants for the complementary pwm and phase counting timer
package cpwm_pkg;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_CH3_CNT   = 8'h08;
  localparam logic [7:0] ADDR_CH4_CNT   = 8'h0C;
  localparam logic [7:0] ADDR_LIMIT     = 8'h10;
  localparam logic [7:0] ADDR_EDGE1     = 8'h14;
  localparam logic [7:0] ADDR_EDGE2     = 8'h18;
  localparam logic [7:0] ADDR_EDGE3     = 8'h1C;
  localparam logic [7:0] ADDR_BUF1      = 8'h20;
  localparam logic [7:0] ADDR_BUF2      = 8'h24;
  localparam logic [7:0] ADDR_BUF3      = 8'h28;
  localparam logic [7:0] ADDR_CH2_CNT   = 8'h2C;
  localparam logic [7:0] ADDR_CH2_CMPA  = 8'h30;
  localparam logic [7:0] ADDR_CH2_CMPB  = 8'h34;
  // control bit positions
  localparam int CTRL_CPWM_EN  = 0;
  localparam int CTRL_RUN      = 1;
  localparam int CTRL_BUF_EN   = 2;
  localparam int CTRL_LVL3     = 3;
  localparam int CTRL_LVL4     = 4;
  localparam int CTRL_PHASE_EN = 5;
  localparam int CTRL_CH2_RUN  = 6;
  localparam int CTRL_CLR_A    = 7;
  localparam int CTRL_CLR_B    = 8;
  localparam int CTRL_W        = 9;
  // status bit positions, write one to clear, except the down bit which follows the direction
  localparam int ST_MATCH_A3 = 0;
  localparam int ST_OVF4     = 1;
  localparam int ST_CH2_A    = 2;
  localparam int ST_CH2_B    = 3;
  localparam int ST_CH2_OVF  = 4;
  localparam int ST_DOWN     = 5;
  localparam int ST_W        = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
endpackage : cpwm_pkg

// ---- rtl/quad_decoder.sv ----
// quadrature edge decoder giving one-cycle up and down pulses
`timescale 1ns/1ps
module quad_decoder (
  // clock and reset
  input  wire logic CLK,
  input  wire logic SRST,
  // encoder levels, synchronous to the clock
  input  wire logic a_in,
  input  wire logic b_in,
  // count pulses
  output logic      up,
  output logic      down
);
  logic a_ff;
  logic b_ff;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else begin
      a_ff <= a_in;
      b_ff <= b_in;
    end
  end

  logic a_edge;
  logic b_edge;
  logic up_a;
  logic up_b;
  assign a_edge = a_ff ^ a_in;
  assign b_edge = b_ff ^ b_in;
  // a leads b: a rising with b low, a falling with b high
  assign up_a = a_edge & (a_in ^ b_in);
  // b rising with a high, b falling with a low
  assign up_b = b_edge & ~(a_in ^ b_in);
  // every edge of either input counts; simultaneous edges cancel
  assign up   = (up_a | up_b) & ~(a_edge & b_edge);
  assign down = ((a_edge & ~up_a) | (b_edge & ~up_b)) & ~(a_edge & b_edge);
endmodule : quad_decoder

// ---- rtl/cpwm_timer.sv ----
// complementary three-phase pwm and phase counting timer, axi4-lite slave
//
// What this block does
// - complementary mode joins channels 3 and 4 into three non-overlapping pwm pairs
// - mode turns six pins into pwm outputs; both counters count up and down
// - phase 1 on channel 3 pins, phases 2 and 3 on channel 4 pairs
// - phases toggle on matches with the three edge registers
// - count down on limit match, count up on channel 4 underflow
// - phase 1 edge above limit plus one gives steady 0% or 100% duty
// - counters overshoot and undershoot; flags and transfers use mode conditions
// - channel 3 match-a flag sets only while counting up
// - channel 4 overflow flag sets only on underflow
// - buffers copy at up-count limit match and at channel 4 underflow
// - phase mode: channel 2 counts up or down from quadrature inputs
// - quadrature pins drive the channel 2 count; clear, compare, flags stay operative
// - every edge of either quadrature input is counted unless both change in the same cycle
`timescale 1ns/1ps
module cpwm_timer (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // axi4-lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // quadrature inputs
  input  wire logic        QUAD_IN_A,
  input  wire logic        QUAD_IN_B,
  // phase outputs
  output logic             PHASE1_POS_PIN,
  output logic             PHASE1_NEG_PIN,
  output logic             PHASE2_POS_PIN,
  output logic             PHASE2_NEG_PIN,
  output logic             PHASE3_POS_PIN,
  output logic             PHASE3_NEG_PIN,
  output logic             PWM_ACTIVE
);
  localparam int W = cpwm_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  logic [cpwm_pkg::CTRL_W-1:0] ctrl_ff;
  logic [cpwm_pkg::ST_W-1:0]   status_ff;
  logic [W-1:0] ch3_counter_ff, ch4_counter_ff, ch2_counter_ff;
  logic [W-1:0] ch3_limit_reg_ff;
  logic [W-1:0] edge_ff [3];
  logic [W-1:0] buf_ff  [3];
  logic [W-1:0] ch2_compare_a_ff, ch2_compare_b_ff;
  logic         down_ff;
  logic [2:0]   phase_ff;

  // write channel: take address and data in either order
  logic [7:0]  aw_addr_ff;
  logic        aw_have_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        w_have_ff;
  logic        wr_do;
  logic [31:0] wmask;

  assign AWREADY = ~aw_have_ff & ~BVALID;
  assign WREADY  = ~w_have_ff & ~BVALID;
  assign wr_do   = aw_have_ff & w_have_ff & ~BVALID;
  assign wmask   = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_addr_ff <= 8'h00;
      aw_have_ff <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      w_have_ff  <= 1'b0;
      BVALID     <= 1'b0;
      BRESP      <= cpwm_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_addr_ff <= AWADDR;
        aw_have_ff <= 1'b1;
      end
      if (WVALID && WREADY) begin
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
        w_have_ff <= 1'b1;
      end
      if (wr_do) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        BVALID     <= 1'b1;
        BRESP      <= (aw_addr_ff > cpwm_pkg::ADDR_CH2_CMPB || aw_addr_ff[1:0] != 2'h0) ?
                      cpwm_pkg::RESP_SLVERR : cpwm_pkg::RESP_OKAY;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  function automatic logic [W-1:0] merge16(input logic [W-1:0] old, input logic [31:0] d,
                                            input logic [31:0] m);
    merge16 = (old & ~m[W-1:0]) | (d[W-1:0] & m[W-1:0]);
  endfunction : merge16

  function automatic logic wr_hit(input logic [7:0] a, input logic go, input logic [7:0] t);
    wr_hit = go && (a == t);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // complementary pwm counters
  logic cpwm_on;
  logic run;
  logic lim_match, under4, turn_top;
  assign cpwm_on   = ctrl_ff[cpwm_pkg::CTRL_CPWM_EN];
  assign run       = cpwm_on & ctrl_ff[cpwm_pkg::CTRL_RUN];
  assign lim_match = run & ~down_ff & (ch3_counter_ff == ch3_limit_reg_ff);
  assign under4    = run & down_ff & (ch4_counter_ff == cpwm_pkg::CNT_ZERO);
  assign turn_top  = lim_match;
  assign PWM_ACTIVE = cpwm_on;

  // direction turns at the limit match and at channel 4 underflow
  always_ff @(posedge CLK) begin
    if (SRST) begin
      down_ff <= 1'b0;
    end else if (!cpwm_on) begin
      down_ff <= 1'b0;
    end else if (turn_top) begin
      down_ff <= 1'b1;
    end else if (under4) begin
      down_ff <= 1'b0;
    end
  end

  // both counters count together; the match cycle itself still moves them,
  // which gives the overshoot at the top and undershoot below zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ch3_counter_ff <= cpwm_pkg::CNT_ZERO;
      ch4_counter_ff <= cpwm_pkg::CNT_ZERO;
    end else if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CH3_CNT)) begin
      ch3_counter_ff <= merge16(ch3_counter_ff, w_data_ff, wmask);
    end else if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CH4_CNT)) begin
      ch4_counter_ff <= merge16(ch4_counter_ff, w_data_ff, wmask);
    end else if (run) begin
      if (down_ff) begin
        ch3_counter_ff <= ch3_counter_ff - cpwm_pkg::CNT_ONE;
        ch4_counter_ff <= ch4_counter_ff - cpwm_pkg::CNT_ONE;
      end else begin
        ch3_counter_ff <= ch3_counter_ff + cpwm_pkg::CNT_ONE;
        ch4_counter_ff <= ch4_counter_ff + cpwm_pkg::CNT_ONE;
      end
    end
  end

  // phase outputs toggle on edge matches; phase 1 uses channel 3, others channel 4.
  // a phase 1 edge above limit plus one never matches, so that phase holds steady
  logic [2:0] hit;
  assign hit[0] = run & (ch3_counter_ff == edge_ff[0]);
  genvar gi;
  generate
    for (gi = 1; gi < 3; gi++) begin : g_ch4hit
      assign hit[gi] = run & (ch4_counter_ff == edge_ff[gi]);
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (SRST || !cpwm_on) begin
      phase_ff <= 3'h0;
    end else begin
      phase_ff <= phase_ff ^ hit;
    end
  end

  // pins: positive and complement, each pair from one flop; level selects invert
  logic lvl3, lvl4;
  assign lvl3 = ctrl_ff[cpwm_pkg::CTRL_LVL3];
  assign lvl4 = ctrl_ff[cpwm_pkg::CTRL_LVL4];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PHASE1_POS_PIN <= 1'b0;
      PHASE1_NEG_PIN <= 1'b0;
      PHASE2_POS_PIN <= 1'b0;
      PHASE2_NEG_PIN <= 1'b0;
      PHASE3_POS_PIN <= 1'b0;
      PHASE3_NEG_PIN <= 1'b0;
    end else if (cpwm_on) begin
      PHASE1_POS_PIN <= nxt_pos(phase_ff[0], lvl3);
      PHASE1_NEG_PIN <= ~nxt_pos(phase_ff[0], lvl3);
      PHASE2_POS_PIN <= nxt_pos(phase_ff[1], lvl4);
      PHASE2_NEG_PIN <= ~nxt_pos(phase_ff[1], lvl4);
      PHASE3_POS_PIN <= nxt_pos(phase_ff[2], lvl4);
      PHASE3_NEG_PIN <= ~nxt_pos(phase_ff[2], lvl4);
    end else begin
      PHASE1_POS_PIN <= 1'b0;
      PHASE1_NEG_PIN <= 1'b0;
      PHASE2_POS_PIN <= 1'b0;
      PHASE2_NEG_PIN <= 1'b0;
      PHASE3_POS_PIN <= 1'b0;
      PHASE3_NEG_PIN <= 1'b0;
    end
  end

  function automatic logic nxt_pos(input logic ph, input logic lvl);
    nxt_pos = ph ^ ~lvl;
  endfunction : nxt_pos

  // buffered edges copy at the up-count limit match and at underflow
  logic xfer;
  assign xfer = ctrl_ff[cpwm_pkg::CTRL_BUF_EN] & (lim_match | under4);

  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      logic [7:0] ea, ba;
      assign ea = cpwm_pkg::ADDR_EDGE1 + 8'(4 * gi);
      assign ba = cpwm_pkg::ADDR_BUF1 + 8'(4 * gi);
      always_ff @(posedge CLK) begin
        if (SRST) begin
          edge_ff[gi] <= cpwm_pkg::CNT_MAX;
          buf_ff[gi]  <= cpwm_pkg::CNT_MAX;
        end else begin
          if (wr_hit(aw_addr_ff, wr_do, ba)) begin
            buf_ff[gi] <= merge16(buf_ff[gi], w_data_ff, wmask);
          end
          if (xfer) begin
            edge_ff[gi] <= buf_ff[gi];
          end else if (wr_hit(aw_addr_ff, wr_do, ea)) begin
            edge_ff[gi] <= merge16(edge_ff[gi], w_data_ff, wmask);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // phase counting on channel 2
  logic q_up, q_dn, ch2_step, ch2_a, ch2_b, ch2_ovf;
  quad_decoder u_quad (
    .CLK  (CLK),
    .SRST (SRST),
    .a_in (QUAD_IN_A),
    .b_in (QUAD_IN_B),
    .up   (q_up),
    .down (q_dn)
  );
  assign ch2_step = ctrl_ff[cpwm_pkg::CTRL_PHASE_EN] & ctrl_ff[cpwm_pkg::CTRL_CH2_RUN];
  assign ch2_a   = ch2_step & (q_up | q_dn) & (ch2_counter_ff == ch2_compare_a_ff);
  assign ch2_b   = ch2_step & (q_up | q_dn) & (ch2_counter_ff == ch2_compare_b_ff);
  assign ch2_ovf = ch2_step & ((q_up & (ch2_counter_ff == cpwm_pkg::CNT_MAX)) |
                               (q_dn & (ch2_counter_ff == cpwm_pkg::CNT_ZERO)));

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ch2_counter_ff <= cpwm_pkg::CNT_ZERO;
    end else if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CH2_CNT)) begin
      ch2_counter_ff <= merge16(ch2_counter_ff, w_data_ff, wmask);
    end else if ((ch2_a && ctrl_ff[cpwm_pkg::CTRL_CLR_A]) ||
                 (ch2_b && ctrl_ff[cpwm_pkg::CTRL_CLR_B])) begin
      ch2_counter_ff <= cpwm_pkg::CNT_ZERO;
    end else if (ch2_step && q_up) begin
      ch2_counter_ff <= ch2_counter_ff + cpwm_pkg::CNT_ONE;
    end else if (ch2_step && q_dn) begin
      ch2_counter_ff <= ch2_counter_ff - cpwm_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, limit and channel 2 compare registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_ff          <= '0;
      ch3_limit_reg_ff <= cpwm_pkg::CNT_MAX;
      ch2_compare_a_ff <= cpwm_pkg::CNT_MAX;
      ch2_compare_b_ff <= cpwm_pkg::CNT_MAX;
    end else begin
      if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CTRL)) begin
        ctrl_ff <= (ctrl_ff & ~wmask[cpwm_pkg::CTRL_W-1:0]) |
                   (w_data_ff[cpwm_pkg::CTRL_W-1:0] & wmask[cpwm_pkg::CTRL_W-1:0]);
      end
      if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_LIMIT)) begin
        ch3_limit_reg_ff <= merge16(ch3_limit_reg_ff, w_data_ff, wmask);
      end
      if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CH2_CMPA)) begin
        ch2_compare_a_ff <= merge16(ch2_compare_a_ff, w_data_ff, wmask);
      end
      if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_CH2_CMPB)) begin
        ch2_compare_b_ff <= merge16(ch2_compare_b_ff, w_data_ff, wmask);
      end
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  logic [cpwm_pkg::ST_W-1:0] set_v, clr_v;
  always_comb begin
    set_v = '0;
    set_v[cpwm_pkg::ST_MATCH_A3] = lim_match;
    set_v[cpwm_pkg::ST_OVF4]     = under4;
    set_v[cpwm_pkg::ST_CH2_A]    = ch2_a;
    set_v[cpwm_pkg::ST_CH2_B]    = ch2_b;
    set_v[cpwm_pkg::ST_CH2_OVF]  = ch2_ovf;
    clr_v = '0;
    if (wr_hit(aw_addr_ff, wr_do, cpwm_pkg::ADDR_STATUS) && w_strb_ff[0]) begin
      clr_v = w_data_ff[cpwm_pkg::ST_W-1:0];
    end
    clr_v[cpwm_pkg::ST_DOWN] = 1'b0;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~clr_v) | set_v;
      status_ff[cpwm_pkg::ST_DOWN] <= down_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle to answer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ARADDR)
      cpwm_pkg::ADDR_CTRL:     rd_mux[cpwm_pkg::CTRL_W-1:0] = ctrl_ff;
      cpwm_pkg::ADDR_STATUS:   rd_mux[cpwm_pkg::ST_W-1:0]   = status_ff;
      cpwm_pkg::ADDR_CH3_CNT:  rd_mux[W-1:0] = ch3_counter_ff;
      cpwm_pkg::ADDR_CH4_CNT:  rd_mux[W-1:0] = ch4_counter_ff;
      cpwm_pkg::ADDR_LIMIT:    rd_mux[W-1:0] = ch3_limit_reg_ff;
      cpwm_pkg::ADDR_EDGE1:    rd_mux[W-1:0] = edge_ff[0];
      cpwm_pkg::ADDR_EDGE2:    rd_mux[W-1:0] = edge_ff[1];
      cpwm_pkg::ADDR_EDGE3:    rd_mux[W-1:0] = edge_ff[2];
      cpwm_pkg::ADDR_BUF1:     rd_mux[W-1:0] = buf_ff[0];
      cpwm_pkg::ADDR_BUF2:     rd_mux[W-1:0] = buf_ff[1];
      cpwm_pkg::ADDR_BUF3:     rd_mux[W-1:0] = buf_ff[2];
      cpwm_pkg::ADDR_CH2_CNT:  rd_mux[W-1:0] = ch2_counter_ff;
      cpwm_pkg::ADDR_CH2_CMPA: rd_mux[W-1:0] = ch2_compare_a_ff;
      cpwm_pkg::ADDR_CH2_CMPB: rd_mux[W-1:0] = ch2_compare_b_ff;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  assign ARREADY = ~RVALID;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= cpwm_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_mux;
      RRESP  <= (ARADDR > cpwm_pkg::ADDR_CH2_CMPB || ARADDR[1:0] != 2'h0) ?
                cpwm_pkg::RESP_SLVERR : cpwm_pkg::RESP_OKAY;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule : cpwm_timer

// ---- verification/cpwm_timer_sva.sv ----
// port checker for cpwm_timer
`timescale 1ns/1ps
module cpwm_timer_sva (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // register bus
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // pwm pins
  input wire logic        PHASE1_POS_PIN,
  input wire logic        PHASE1_NEG_PIN,
  input wire logic        PHASE2_POS_PIN,
  input wire logic        PHASE2_NEG_PIN,
  input wire logic        PHASE3_POS_PIN,
  input wire logic        PHASE3_NEG_PIN,
  input wire logic        PWM_ACTIVE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  ////////////////////////////////////////
  // pins are flops behind the mode bit, so let them settle first
  sequence s_on;
    PWM_ACTIVE [*3];
  endsequence
  sequence s_off;
    !PWM_ACTIVE [*3];
  endsequence
  property p_rst_idle;
    $fell(SRST) |-> !BVALID && !RVALID && !PHASE1_POS_PIN;
  endproperty
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  property p_b_block;
    BVALID |-> !AWREADY && !WREADY;
  endproperty
  property p_r_answer;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  property p_pair1;
    s_on |-> PHASE1_NEG_PIN == !PHASE1_POS_PIN;
  endproperty
  property p_pair2;
    s_on |-> PHASE2_NEG_PIN == !PHASE2_POS_PIN;
  endproperty
  property p_pair3;
    s_on |-> PHASE3_NEG_PIN == !PHASE3_POS_PIN;
  endproperty
  property p_off_low;
    s_off |-> {PHASE1_POS_PIN, PHASE1_NEG_PIN, PHASE2_POS_PIN,
               PHASE2_NEG_PIN, PHASE3_POS_PIN, PHASE3_NEG_PIN} == 6'h00;
  endproperty
  ////////////////////////////////////////
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs busy after reset");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");
  a_b_block: assert property (p_b_block)
    else $error("write taken during response");
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  a_pair1: assert property (p_pair1)
    else $error("phase 1 pair not complementary");
  a_pair2: assert property (p_pair2)
    else $error("phase 2 pair not complementary");
  a_pair3: assert property (p_pair3)
    else $error("phase 3 pair not complementary");
  a_off_low: assert property (p_off_low)
    else $error("pins driven with mode off");
endmodule : cpwm_timer_sva

bind cpwm_timer cpwm_timer_sva chk (.CLK(CLK), .SRST(SRST),
  .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RVALID(RVALID), .RREADY(RREADY), .PHASE1_POS_PIN(PHASE1_POS_PIN),
  .PHASE1_NEG_PIN(PHASE1_NEG_PIN), .PHASE2_POS_PIN(PHASE2_POS_PIN),
  .PHASE2_NEG_PIN(PHASE2_NEG_PIN), .PHASE3_POS_PIN(PHASE3_POS_PIN),
  .PHASE3_NEG_PIN(PHASE3_NEG_PIN), .PWM_ACTIVE(PWM_ACTIVE));

// ---- verification/quad_encoder_model.sv ----
// quadrature encoder model stepping a gray sequence on request
`timescale 1ns/1ps
module quad_encoder_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // step request
  input wire logic       start,
  input wire logic       fwd,
  input wire logic [7:0] steps,
  output logic           busy,
  // encoder lines
  output logic           qa,
  output logic           qb
);
  logic [1:0] idx_ff;
  logic [7:0] left_ff;
  logic [1:0] gap_ff;
  logic       fwd_ff;
  ////////////////////////////////////////
  // four clocks a step: levels last eight, phase gap four
  always_ff @(posedge clk) begin
    if (srst) begin
      idx_ff  <= 2'h0;
      left_ff <= 8'h00;
      gap_ff  <= 2'h0;
      fwd_ff  <= 1'b1;
    end else if (start && !busy) begin
      left_ff <= steps;
      fwd_ff  <= fwd;
      gap_ff  <= 2'h0;
    end else if (busy) begin
      gap_ff <= gap_ff + 2'h1;
      if (gap_ff == 2'h3) begin
        idx_ff  <= fwd_ff ? idx_ff + 2'h1 : idx_ff - 2'h1;
        left_ff <= left_ff - 8'h01;
      end
    end
  end
  assign busy = (left_ff != 8'h00);
  // forward order lets a lead b
  assign qa   = idx_ff[1] ^ idx_ff[0];
  assign qb   = idx_ff[1];
endmodule : quad_encoder_model

// ---- verification/test_cpwm_timer.sv ----
// self-checking bench for cpwm_timer
`timescale 1ns/1ps
module test_cpwm_timer;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic [7:0]  AWADDR = 8'h00;
  logic        AWVALID = 1'b0;
  logic        AWREADY;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  WSTRB = 4'hF;
  logic        late_ready = 1'b0;
  logic        WVALID = 1'b0;
  logic        WREADY;
  logic [1:0]  BRESP;
  logic        BVALID;
  logic        BREADY = 1'b0;
  logic [7:0]  ARADDR = 8'h00;
  logic        ARVALID = 1'b0;
  logic        ARREADY;
  logic [31:0] RDATA;
  logic [1:0]  RRESP;
  logic        RVALID;
  logic        RREADY = 1'b0;
  logic        QUAD_IN_A;
  logic        QUAD_IN_B;
  logic [5:0]  pins;
  logic        PWM_ACTIVE;
  logic        enc_start = 1'b0;
  logic        enc_fwd = 1'b1;
  logic [7:0]  enc_steps = 8'h00;
  logic        enc_busy;
  logic [1:0]  resp;
  logic [31:0] rd;
  int          n;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  cpwm_timer dut (.CLK(CLK), .SRST(SRST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .QUAD_IN_A(QUAD_IN_A), .QUAD_IN_B(QUAD_IN_B),
    .PHASE1_POS_PIN(pins[0]), .PHASE1_NEG_PIN(pins[1]),
    .PHASE2_POS_PIN(pins[2]), .PHASE2_NEG_PIN(pins[3]),
    .PHASE3_POS_PIN(pins[4]), .PHASE3_NEG_PIN(pins[5]),
    .PWM_ACTIVE(PWM_ACTIVE));
  quad_encoder_model encoder (.clk(CLK), .srst(SRST), .start(enc_start),
    .fwd(enc_fwd), .steps(enc_steps), .busy(enc_busy),
    .qa(QUAD_IN_A), .qb(QUAD_IN_B));
  ////////////////////////////////////////
  initial begin
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checked++;
    if (act !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] exp);
    chk({30'h0, resp}, {30'h0, exp});
  endtask : chk_resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= !late_ready;
    forever begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
      if (BVALID) BREADY <= 1'b1;
    end
    resp = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= !late_ready;
    forever begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
      if (RVALID) RREADY <= 1'b1;
    end
    rd = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask : rd_reg
  // window of whole periods, so the count is phase independent
  task automatic toggles(input int s, input int len);
    logic last;
    n = 0;
    @(posedge CLK);
    last = pins[s];
    repeat (len) begin
      @(posedge CLK);
      if (pins[s] !== last) n++;
      last = pins[s];
    end
  endtask : toggles
  task automatic quad_steps(input logic f, input logic [7:0] k);
    @(posedge CLK);
    enc_fwd   <= f;
    enc_steps <= k;
    enc_start <= 1'b1;
    @(posedge CLK);
    enc_start <= 1'b0;
    do @(posedge CLK); while (enc_busy);
    repeat (5) @(posedge CLK);
  endtask : quad_steps
  ////////////////////////////////////////
  task automatic test_regs();
    rd_reg(cpwm_pkg::ADDR_LIMIT);
    chk(rd, 32'h0000FFFF);
    chk_resp(cpwm_pkg::RESP_OKAY);
    rd_reg(cpwm_pkg::ADDR_STATUS);
    chk(rd, 32'h00000000);
    rd_reg(8'h38);
    chk_resp(cpwm_pkg::RESP_SLVERR);
    chk(rd, 32'h00000000);
    wr(8'h38, 32'h00001234);
    chk_resp(cpwm_pkg::RESP_SLVERR);
    wr(cpwm_pkg::ADDR_CH2_CMPA, 32'hFFFF0003);
    rd_reg(cpwm_pkg::ADDR_CH2_CMPA);
    chk(rd, 32'h00000003);
    WSTRB <= 4'h1;
    wr(cpwm_pkg::ADDR_CH2_CMPB, 32'h00005678);
    WSTRB <= 4'hF;
    rd_reg(cpwm_pkg::ADDR_CH2_CMPB);
    chk(rd, 32'h0000FF78);
    $display("test_regs done");
  endtask : test_regs
  // margin 4, limit 0x20: a 60 cycle period, two toggles a phase
  task automatic test_pwm();
    wr(cpwm_pkg::ADDR_CH4_CNT, 32'h0);
    wr(cpwm_pkg::ADDR_CH3_CNT, 32'h4);
    wr(cpwm_pkg::ADDR_LIMIT, 32'h20);
    wr(cpwm_pkg::ADDR_EDGE1, 32'h10);
    wr(cpwm_pkg::ADDR_EDGE2, 32'h0C);
    wr(cpwm_pkg::ADDR_EDGE3, 32'h14);
    wr(cpwm_pkg::ADDR_CTRL, 32'h1B);
    chk({31'h0, PWM_ACTIVE}, 32'h1);
    repeat (100) @(posedge CLK);
    toggles(0, 120);
    chk(n, 4);
    toggles(2, 120);
    chk(n, 4);
    toggles(4, 120);
    chk(n, 4);
    rd_reg(cpwm_pkg::ADDR_STATUS);
    chk(rd & 32'h3, 32'h3);
    wr(cpwm_pkg::ADDR_CTRL, 32'h19);
    wr(cpwm_pkg::ADDR_STATUS, 32'h3);
    rd_reg(cpwm_pkg::ADDR_STATUS);
    chk(rd & 32'h3, 32'h0);
    $display("test_pwm done");
  endtask : test_pwm
  task automatic test_buffer();
    wr(cpwm_pkg::ADDR_BUF2, 32'h0C);
    wr(cpwm_pkg::ADDR_BUF3, 32'h14);
    wr(cpwm_pkg::ADDR_BUF1, 32'hFFFF);
    wr(cpwm_pkg::ADDR_CTRL, 32'h1F);
    repeat (150) @(posedge CLK);
    rd_reg(cpwm_pkg::ADDR_EDGE1);
    chk(rd, 32'h0000FFFF);
    toggles(0, 120);
    chk(n, 0);
    toggles(2, 120);
    chk(n, 4);
    $display("test_buffer done");
  endtask : test_buffer
  // limit lowered mid down-count: passing it downward must leave match-a clear
  task automatic test_down_flag();
    wr(cpwm_pkg::ADDR_CTRL, 32'h0);
    wr(cpwm_pkg::ADDR_CH4_CNT, 32'h0);
    wr(cpwm_pkg::ADDR_CH3_CNT, 32'h4);
    wr(cpwm_pkg::ADDR_LIMIT, 32'h20);
    wr(cpwm_pkg::ADDR_CTRL, 32'h1B);
    repeat (29) @(posedge CLK);
    late_ready = 1'b1;
    wr(cpwm_pkg::ADDR_STATUS, 32'h3);
    wr(cpwm_pkg::ADDR_LIMIT, 32'h10);
    repeat (16) @(posedge CLK);
    rd_reg(cpwm_pkg::ADDR_STATUS);
    chk(rd & 32'h1, 32'h0);
    late_ready = 1'b0;
    $display("test_down_flag done");
  endtask : test_down_flag
  task automatic test_quad();
    wr(cpwm_pkg::ADDR_CTRL, 32'h60);
    repeat (5) @(posedge CLK);
    chk({26'h0, pins}, 32'h0);
    chk({31'h0, PWM_ACTIVE}, 32'h0);
    quad_steps(1'b1, 8'h08);
    rd_reg(cpwm_pkg::ADDR_CH2_CNT);
    chk(rd, 32'h8);
    rd_reg(cpwm_pkg::ADDR_STATUS);
    chk(rd & 32'h4, 32'h4);
    quad_steps(1'b0, 8'h03);
    rd_reg(cpwm_pkg::ADDR_CH2_CNT);
    chk(rd, 32'h5);
    $display("test_quad done");
  endtask : test_quad
  task automatic complete_run();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    test_regs();
    test_pwm();
    test_buffer();
    test_down_flag();
    test_quad();
    complete_run();
  end
endmodule : test_cpwm_timer
